// >>> cpu_core_params.svh
/*
 * Offsets, field positions and reset values of the core state block.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef CPU_CORE_PARAMS_SVH
`define CPU_CORE_PARAMS_SVH

`define FLAGS_WORD_ADDR   6'h3F
`define FLAGS_WORD_RESET  8'h00
`define FLAG_GATE_BIT     7
`define FLAG_COPY_BIT     6
`define FLAG_HALF_BIT     5
`define FLAG_SIGN_BIT     4
`define FLAG_OVF_BIT      3
`define FLAG_NEG_BIT      2
`define FLAG_ZERO_BIT     1
`define FLAG_CARRY_BIT    0
`define STACK_DEPTH       3
`define PC_WIDTH          9
`define REG_COUNT         32
`define PTR_LOW_REG       5'h1E
`define PTR_HIGH_REG      5'h1F
`define UPPER_HALF_BIT    4

`endif

// >>> cpu_core_pkg.sv
/*
 * Types shared by the core state block and its register file memory.
 * Assumes cpu_core_params.svh is on the include path.
 */
`include "cpu_core_params.svh"

package cpu_core_pkg;

    typedef logic [`PC_WIDTH-1:0] pc_t;
    typedef logic [7:0]           byte_t;
    typedef logic [4:0]           reg_idx_t;

    typedef enum logic [1:0] {
        STK_HOLD = 2'b00,
        STK_PUSH = 2'b01,
        STK_POP  = 2'b11
    } stack_op_e;

    typedef struct packed {
        logic imm_form;
        logic indirect;
        logic rd_en;
        logic rr_en;
        reg_idx_t rd;
        reg_idx_t rr;
    } operand_sel_s;

    typedef struct packed {
        logic  we;
        byte_t data;
    } write_back_s;

    typedef struct packed {
        logic flags_we;
        logic h;
        logic v;
        logic n;
        logic z;
        logic c;
    } alu_flags_s;

endpackage : cpu_core_pkg

// >>> regfile_mem.sv
/*
 * Working register memory: 32 bytes, two registered read ports and one
 * write port. Assumes a single clock; contents are not reset.
 */
`include "cpu_core_params.svh"

module regfile_mem (
    input  wire logic                  i_clock,
    input  wire cpu_core_pkg::reg_idx_t i_raddr_a,
    input  wire cpu_core_pkg::reg_idx_t i_raddr_b,
    input  wire logic                  i_we,
    input  wire cpu_core_pkg::reg_idx_t i_waddr,
    input  wire cpu_core_pkg::byte_t    i_wdata,
    output cpu_core_pkg::byte_t         o_rdata_a,
    output cpu_core_pkg::byte_t         o_rdata_b,
    output cpu_core_pkg::byte_t         o_ptr_low,
    output cpu_core_pkg::byte_t         o_ptr_high
);

    cpu_core_pkg::byte_t mem_q [`REG_COUNT];

    always_ff @(posedge i_clock) begin
        if (i_we) begin
            mem_q[i_waddr] <= i_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        o_rdata_a <= mem_q[i_raddr_a];
        o_rdata_b <= mem_q[i_raddr_b];
    end

    assign o_ptr_low  = mem_q[`PTR_LOW_REG];
    assign o_ptr_high = mem_q[`PTR_HIGH_REG];

endmodule : regfile_mem

// >>> cpu_regfile_stack_flags.sv
/*
 * Core state of the 8-bit processor: working registers, return stack and
 * the flag word. Assumes the decoder presents operand selects one cycle
 * before the operands are used, and the arithmetic unit returns results
 * and flag values combinationally in the cycle it sees the operands.
 */
`include "cpu_core_params.svh"

module cpu_regfile_stack_flags (
    input  wire logic                      I_CLOCK,
    input  wire logic                      I_ARST_N,
    input  wire cpu_core_pkg::stack_op_e   I_STACK_OP,
    input  wire logic                      I_IRQ_ENTRY,
    input  wire logic                      I_IRQ_EXIT,
    input  wire cpu_core_pkg::pc_t         I_RETURN_PC,
    input  wire cpu_core_pkg::operand_sel_s I_OPERAND_SEL,
    input  wire cpu_core_pkg::write_back_s I_WRITE_BACK,
    input  wire cpu_core_pkg::alu_flags_s  I_ALU_FLAGS,
    input  wire logic                      I_IRQ_PENDING,
    input  wire logic                      I_IO_WE,
    input  wire logic [5:0]                I_IO_ADDR,
    input  wire cpu_core_pkg::byte_t       I_IO_WDATA,
    input  wire logic                      I_COPY_STORE,
    input  wire logic                      I_COPY_LOAD,
    input  wire logic [2:0]                I_BIT_SEL,
    output cpu_core_pkg::pc_t              O_POP_PC,
    output cpu_core_pkg::byte_t            O_OPERAND_A,
    output cpu_core_pkg::byte_t            O_OPERAND_B,
    output logic [15:0]                    O_POINTER,
    output cpu_core_pkg::byte_t            O_FLAGS,
    output cpu_core_pkg::byte_t            O_IO_RDATA,
    output logic                           O_IRQ_TAKE
);

    cpu_core_pkg::pc_t   stack_q [`STACK_DEPTH];
    cpu_core_pkg::byte_t flags_q;
    cpu_core_pkg::byte_t flags_d;
    cpu_core_pkg::byte_t ptr_low;
    cpu_core_pkg::byte_t ptr_high;
    cpu_core_pkg::byte_t rdata_a;
    cpu_core_pkg::byte_t rdata_b;
    cpu_core_pkg::byte_t wb_data;
    cpu_core_pkg::reg_idx_t raddr_a;
    cpu_core_pkg::reg_idx_t raddr_b;
    cpu_core_pkg::reg_idx_t waddr_q;
    logic [2:0]          bit_q;
    logic                load_q;
    logic                store_q;
    logic                wb_we;
    logic                push;
    logic                pop;
    logic                n_new;
    logic                v_new;

    // Immediate forms force the top index bit so only the upper half is hit.
    function automatic cpu_core_pkg::reg_idx_t upper_only(
        input cpu_core_pkg::reg_idx_t idx,
        input logic                   imm
    );
        cpu_core_pkg::reg_idx_t r;
        r = idx;
        if (imm) begin
            r[`UPPER_HALF_BIT] = 1'b1;
        end
        return r;
    endfunction : upper_only

    assign push = (I_STACK_OP == cpu_core_pkg::STK_PUSH) || I_IRQ_ENTRY;
    assign pop  = (I_STACK_OP == cpu_core_pkg::STK_POP) || I_IRQ_EXIT;

    // Push shifts down and loses the oldest; pop shifts up keeping bottom.
    always_ff @(posedge I_CLOCK) begin
        if (push) begin
            stack_q[0] <= I_RETURN_PC;
            stack_q[1] <= stack_q[0];
            stack_q[2] <= stack_q[1];
        end else if (pop) begin
            stack_q[0] <= stack_q[1];
            stack_q[1] <= stack_q[2];
        end
    end

    assign O_POP_PC = stack_q[0];

    // The indirect access reads only the pointer low byte.
    assign raddr_a = I_OPERAND_SEL.indirect ? ptr_low[4:0] :
                     upper_only(I_OPERAND_SEL.rd,
                                I_OPERAND_SEL.imm_form);
    assign raddr_b = I_OPERAND_SEL.rr;

    always_ff @(posedge I_CLOCK) begin
        waddr_q <= raddr_a;
        bit_q   <= I_BIT_SEL;
        load_q  <= I_COPY_LOAD;
        store_q <= I_COPY_STORE;
    end

    // Bit load merges the copy flag into the destination byte.
    always_comb begin
        wb_data = I_WRITE_BACK.data;
        if (load_q) begin
            wb_data = rdata_a;
            wb_data[bit_q] = flags_q[`FLAG_COPY_BIT];
        end
    end

    assign wb_we = I_WRITE_BACK.we || load_q;

    regfile_mem u_mem (
        .i_clock    (I_CLOCK),
        .i_raddr_a  (raddr_a),
        .i_raddr_b  (raddr_b),
        .i_we       (wb_we),
        .i_waddr    (waddr_q),
        .i_wdata    (wb_data),
        .o_rdata_a  (rdata_a),
        .o_rdata_b  (rdata_b),
        .o_ptr_low  (ptr_low),
        .o_ptr_high (ptr_high)
    );

    assign O_OPERAND_A = rdata_a;
    assign O_OPERAND_B = rdata_b;
    assign O_POINTER   = {ptr_high, ptr_low};

    assign n_new = I_ALU_FLAGS.n;
    assign v_new = I_ALU_FLAGS.v;

    // Entry clears the gate and leaves the rest; the return PC is stacked, the flags are not.
    always_comb begin
        flags_d = flags_q;
        if (I_IO_WE && I_IO_ADDR == `FLAGS_WORD_ADDR) begin
            flags_d = I_IO_WDATA;
        end
        if (I_ALU_FLAGS.flags_we) begin
            flags_d[`FLAG_HALF_BIT]  = I_ALU_FLAGS.h;
            flags_d[`FLAG_OVF_BIT]   = v_new;
            flags_d[`FLAG_NEG_BIT]   = n_new;
            flags_d[`FLAG_ZERO_BIT]  = I_ALU_FLAGS.z;
            flags_d[`FLAG_CARRY_BIT] = I_ALU_FLAGS.c;
        end
        if (store_q) begin
            flags_d[`FLAG_COPY_BIT] = rdata_a[bit_q];
        end
        if (I_IRQ_ENTRY) begin
            flags_d[`FLAG_GATE_BIT] = 1'b0;
        end else if (I_IRQ_EXIT) begin
            flags_d[`FLAG_GATE_BIT] = 1'b1;
        end
        flags_d[`FLAG_SIGN_BIT] = flags_d[`FLAG_NEG_BIT] ^
                                  flags_d[`FLAG_OVF_BIT];
    end

    always_ff @(posedge I_CLOCK or negedge I_ARST_N) begin
        if (!I_ARST_N) begin
            flags_q <= `FLAGS_WORD_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign O_FLAGS    = flags_q;
    assign O_IO_RDATA = (I_IO_ADDR == `FLAGS_WORD_ADDR) ? flags_q : 8'h00;
    assign O_IRQ_TAKE = I_IRQ_PENDING && flags_q[`FLAG_GATE_BIT];

endmodule : cpu_regfile_stack_flags

// >>> cpu_regfile_stack_flags_sva.sv
/* Port checker of the core state block.
   Assumes it is bound into cpu_regfile_stack_flags. */
module cpu_regfile_stack_flags_sva (
    input wire logic                     I_CLOCK,
    input wire logic                     I_ARST_N,
    input wire cpu_core_pkg::stack_op_e  I_STACK_OP,
    input wire logic                     I_IRQ_ENTRY,
    input wire logic                     I_IRQ_EXIT,
    input wire cpu_core_pkg::pc_t        I_RETURN_PC,
    input wire cpu_core_pkg::alu_flags_s I_ALU_FLAGS,
    input wire logic [5:0]               I_IO_ADDR,
    input wire cpu_core_pkg::pc_t        O_POP_PC,
    input wire cpu_core_pkg::byte_t      O_FLAGS,
    input wire cpu_core_pkg::byte_t      O_IO_RDATA
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_ARST_N);
    logic do_push;
    logic do_pop;
    assign do_push = I_STACK_OP == cpu_core_pkg::STK_PUSH || I_IRQ_ENTRY;
    assign do_pop = (I_STACK_OP == cpu_core_pkg::STK_POP || I_IRQ_EXIT)
                    && !do_push;
    property p_rst; $rose(I_ARST_N) |-> O_FLAGS == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("flags not clear");
    property p_sign; O_FLAGS[4] == (O_FLAGS[2] ^ O_FLAGS[3]); endproperty
    a_sign: assert property (p_sign) else $error("sign flag");
    property p_push; do_push |=> O_POP_PC == $past(I_RETURN_PC); endproperty
    a_push: assert property (p_push) else $error("push top");
    property p_pop;
        do_push ##1 do_push ##1 do_pop |=> O_POP_PC == $past(I_RETURN_PC, 3);
    endproperty
    a_pop: assert property (p_pop) else $error("pop order");
    property p_gclr; I_IRQ_ENTRY |=> !O_FLAGS[7]; endproperty
    a_gclr: assert property (p_gclr) else $error("gate clear");
    property p_gset; I_IRQ_EXIT && !I_IRQ_ENTRY |=> O_FLAGS[7]; endproperty
    a_gset: assert property (p_gset) else $error("gate set");
    property p_io; O_IO_RDATA == (I_IO_ADDR == 6'h3F ? O_FLAGS : 8'h00);
    endproperty
    a_io: assert property (p_io) else $error("flag read");
    property p_alu;
        I_ALU_FLAGS.flags_we |=>
            {O_FLAGS[5], O_FLAGS[3:0]} == $past(I_ALU_FLAGS[4:0]);
    endproperty
    a_alu: assert property (p_alu) else $error("alu flags");
    c_push: cover property (do_push [*4]);
    c_pop: cover property (do_pop);
    c_irq: cover property (I_IRQ_ENTRY ##1 I_IRQ_EXIT);
endmodule : cpu_regfile_stack_flags_sva

bind cpu_regfile_stack_flags cpu_regfile_stack_flags_sva chk_u (
    .I_CLOCK, .I_ARST_N, .I_STACK_OP, .I_IRQ_ENTRY, .I_IRQ_EXIT,
    .I_RETURN_PC, .I_ALU_FLAGS, .I_IO_ADDR, .O_POP_PC, .O_FLAGS,
    .O_IO_RDATA);

// >>> exec_model.sv
/* Execution side model: loads an immediate or adds both operands.
   Assumes ops arrive at the falling edge together with the select. */
module exec_model (
    input  wire logic                 i_clock,
    input  wire logic [1:0]           i_op,
    input  wire cpu_core_pkg::byte_t  i_imm,
    input  wire cpu_core_pkg::byte_t  i_a,
    input  wire cpu_core_pkg::byte_t  i_b,
    output cpu_core_pkg::write_back_s o_wb,
    output cpu_core_pkg::alu_flags_s  o_fl
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0]          op_q = 2'h0;
    cpu_core_pkg::byte_t imm_q = 8'h00;
    logic [8:0]          sum;
    logic [4:0]          nib;
    always @(negedge i_clock) begin
        op_q <= i_op;
        imm_q <= i_imm;
    end
    assign sum = {1'b0, i_a} + {1'b0, i_b};
    assign nib = {1'b0, i_a[3:0]} + {1'b0, i_b[3:0]};
    assign o_wb = '{op_q != 2'h0, op_q == 2'h1 ? imm_q : sum[7:0]};
    assign o_fl = '{op_q == 2'h2, nib[4],
                    (i_a[7] == i_b[7]) && (sum[7] != i_a[7]),
                    sum[7], sum[7:0] == 8'h00, sum[8]};
endmodule : exec_model

// >>> cpu_regfile_stack_flags_test.sv
/* Testbench of the core state block.
   Assumes the design, checker and exec_model are compiled first. */
`define CK(n, e, v) begin comparisons++; if ((v) !== (e)) begin \
    err_total++; $display("CHECK FAILED %s exp %h got %h", n, e, v); end end
module cpu_regfile_stack_flags_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0, rst_n = 1'b0, ent = 1'b0, ext = 1'b0, pnd = 1'b0;
    logic we = 1'b0, cs = 1'b0, cl = 1'b0, tk;
    logic [5:0] adr = 6'h3E;
    logic [2:0] bs = 3'h0;
    logic [1:0] go = 2'h0;
    logic [15:0] ptr;
    cpu_core_pkg::stack_op_e sop = cpu_core_pkg::STK_HOLD;
    cpu_core_pkg::pc_t rpc = 9'h000, top;
    cpu_core_pkg::operand_sel_s sel = '0;
    cpu_core_pkg::write_back_s wb;
    cpu_core_pkg::alu_flags_s fl;
    cpu_core_pkg::byte_t wd = 8'h00, imm = 8'h00, a, b, fw, rd;
    int err_total = 0, comparisons = 0;
    cpu_regfile_stack_flags dut_u (
        .I_CLOCK(clk), .I_ARST_N(rst_n), .I_STACK_OP(sop),
        .I_IRQ_ENTRY(ent), .I_IRQ_EXIT(ext), .I_RETURN_PC(rpc),
        .I_OPERAND_SEL(sel), .I_WRITE_BACK(wb), .I_ALU_FLAGS(fl),
        .I_IRQ_PENDING(pnd), .I_IO_WE(we), .I_IO_ADDR(adr),
        .I_IO_WDATA(wd), .I_COPY_STORE(cs), .I_COPY_LOAD(cl),
        .I_BIT_SEL(bs), .O_POP_PC(top), .O_OPERAND_A(a), .O_OPERAND_B(b),
        .O_POINTER(ptr), .O_FLAGS(fw), .O_IO_RDATA(rd), .O_IRQ_TAKE(tk));
    exec_model exec_u (.i_clock(clk), .i_op(go), .i_imm(imm), .i_a(a),
        .i_b(b), .o_wb(wb), .o_fl(fl));
    task final_report;
        $display("errors %0d comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    // One select cycle; f holds copy load, copy store, indirect, immediate.
    task op(input logic [4:0] d, input logic [4:0] r, input logic [3:0] f,
            input logic [1:0] g, input cpu_core_pkg::byte_t v);
        @(negedge clk);
        sel <= '{f[0], f[1], 1'b1, 1'b1, d, r};
        {cl, cs, go, imm, bs} <= {f[3], f[2], g, v, v[2:0]};
        @(negedge clk);
        {cl, cs, go} <= 4'h0;
    endtask : op
    task iow(input cpu_core_pkg::byte_t v);
        @(negedge clk);
        {we, wd} <= {1'b1, v};
        @(negedge clk);
        we <= 1'b0;
    endtask : iow
    initial begin
        forever #20 clk = ~clk;
    end
    initial begin
        #50000;
        err_total++;
        final_report;
    end
    initial begin
        repeat (10) @(negedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        `CK("unmapped", 8'h00, rd)
        adr <= 6'h3F;
        @(negedge clk);
        `CK("flags", 8'h00, rd)
        for (int i = 0; i < 32; i++) op(i[4:0], 5'h00, 4'h0, 2'h1, 8'h40 ^ i[7:0]);
        for (int i = 0; i < 32; i++) begin
            op(i[4:0], i[4:0] ^ 5'h01, 4'h0, 2'h0, 8'h00);
            `CK("opa", 8'h40 ^ i[7:0], a)
            `CK("opb", 8'h41 ^ i[7:0], b)
        end
        op(5'h03, 5'h00, 4'h1, 2'h1, 8'h5A);
        op(5'h01, 5'h00, 4'h0, 2'h1, 8'h78);
        op(5'h02, 5'h00, 4'h0, 2'h1, 8'h08);
        op(5'h1E, 5'h00, 4'h0, 2'h1, 8'h05);
        op(5'h1F, 5'h00, 4'h0, 2'h1, 8'hC7);
        op(5'h13, 5'h13, 4'h2, 2'h0, 8'h00);
        `CK("ptr", 16'hC705, ptr)
        `CK("indirect", 8'h45, a)
        `CK("upper", 8'h5A, b)
        op(5'h01, 5'h02, 4'h0, 2'h2, 8'h00);
        @(negedge clk);
        `CK("add", 8'h2C, fw)
        op(5'h01, 5'h01, 4'h0, 2'h2, 8'h00);
        @(negedge clk);
        `CK("wrap", 8'h1B, fw)
        op(5'h13, 5'h00, 4'h4, 2'h0, 8'h03);
        op(5'h09, 5'h00, 4'h8, 2'h0, 8'h01);
        @(negedge clk);
        op(5'h09, 5'h01, 4'h0, 2'h0, 8'h00);
        `CK("bit load", 8'h4B, a)
        `CK("sum", 8'h00, b)
        `CK("bit store", 8'h5B, fw)
        iow(8'hFF);
        `CK("sign", 8'hEF, fw)
        pnd <= 1'b1;
        iow(8'h21);
        `CK("gate off", 1'b0, tk)
        iow(8'hA1);
        `CK("gate on", 1'b1, tk)
        {ent, rpc} <= {1'b1, 9'h0AB};
        @(negedge clk);
        {ent, ext} <= 2'b01;
        `CK("entry", 8'h21, fw)
        `CK("pushed", 9'h0AB, top)
        @(negedge clk);
        ext <= 1'b0;
        `CK("exit", 8'hA1, fw)
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            {sop, rpc} <= {cpu_core_pkg::STK_PUSH, 9'h101 + i[8:0]};
        end
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            `CK("pop", (i < 3) ? 9'h104 - i[8:0] : 9'h102, top)
            sop <= cpu_core_pkg::STK_POP;
        end
        @(negedge clk);
        sop <= cpu_core_pkg::STK_HOLD;
        `CK("deepest", 9'h102, top)
        final_report;
    end
endmodule : cpu_regfile_stack_flags_test
